/* logic/mmd_decoder.sv */
/*
 Memory map decoder: routes each core access to SRAM, the 16-bit flash
 array, the internal alias-select register or a register-space region,
 and returns aligned read data with a one-cycle acknowledge.
 Assumes same-clock targets whose read data is valid while their strobe
 is high, and a core that waits for the acknowledge between accesses.
*/
// Contract
// - After reset, flash is aliased into the region at address zero.
// - Clearing bit 0 of alias select maps SRAM at address zero.
// - Words are little endian, lowest byte at lowest address.
// - Bank 0 decodes from 0x90000; top 1152 halfwords are boot page.
// - Bank 1 decodes 0x80000 to 0x90000, 32k halfwords, all user.
// - A 32-bit flash fetch takes two consecutive 16-bit array reads.
// - Flash is split into erase/program pages of 512 bytes.
// - Flash fetch runs full rate for 16-bit, half rate for 32-bit.
// - SRAM is 2k 32-bit words, one access per full word.
// - Fast-bus registers take one cycle, peripheral-bus registers two.
// - Interrupt controller, system control, flash controller and GPIO sit on the fast bus.
// - Register space occupies the top 64 kB; avoid reserved holes.
// - The core sees one linear byte-addressed 32-bit space.
// - Interrupt controller region at 0xFFFF0000 has single-cycle access.
// - System control region at 0xFFFF0200 has single-cycle access.
// - Timer, clock/power, supply-monitor regions have two-cycle access.
`timescale 1ns/10ps

module mmd_decoder #(
    parameter int unsigned SRAM_WORDS = 2048
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input mmd_pkg::mmd_req_s core_req_i,
    output logic core_ack_o,
    output logic [mmd_pkg::DW-1:0] core_rdata_o,
    output logic alias_flash_o,
    output mmd_pkg::mmd_sram_s sram_o,
    input wire logic [mmd_pkg::DW-1:0] sram_rdata_i,
    output mmd_pkg::mmd_flash_s flash_o,
    input wire logic [15:0] flash_rdata_i,
    output mmd_pkg::mmd_reg_s reg_o,
    input wire logic [mmd_pkg::DW-1:0] reg_rdata_i
);
    import mmd_pkg::*;

    localparam logic [31:0] SRAM_SPAN = 32'(SRAM_WORDS * 4);

    if (SRAM_WORDS == 0 || SRAM_WORDS > (1 << SRAM_AW)) begin : g_chk
        $error("SRAM_WORDS does not fit the SRAM address field");
    end

    // The range compares below rely on aligned, disjoint, ordered regions
    if (FL1_BASE[FL_OFS_W-1:0] != '0) begin : g_chk_fl_align
        $error("Flash base is not aligned to the flash span");
    end
    if ((FL_END - FL1_BASE) != (32'h1 << FL_OFS_W)) begin : g_chk_fl_span
        $error("Flash span does not match the flash offset width");
    end
    if (FL0_USER_END <= FL0_BASE || FL0_USER_END >= FL_END) begin : g_chk_boot
        $error("Boot page start lies outside bank 0");
    end
    if (PAGE_SHIFT >= FL_OFS_W) begin : g_chk_page
        $error("Page size exceeds the flash span");
    end
    if (SRAM_BASE < ALIAS_LIMIT || SRAM_BASE + SRAM_SPAN > FL1_BASE) begin : g_chk_sram
        $error("SRAM overlaps the alias window or the flash");
    end
    if (SRAM_SPAN > ALIAS_LIMIT) begin : g_chk_alias_win
        $error("SRAM does not fit the alias window");
    end
    if (REG_BASE[REG_OFS_W-1:0] != '0) begin : g_chk_reg_base
        $error("Register space base is not aligned");
    end
    if (OFS_ALIAS < OFS_SYS || OFS_ALIAS >= OFS_TMR) begin : g_chk_alias_ofs
        $error("Alias select must sit in the system control region");
    end
    if (OFS_SYS >= OFS_TMR || OFS_TMR >= OFS_PWR || OFS_PWR >= OFS_PSM
            || OFS_PSM >= OFS_SLOW || OFS_SLOW >= OFS_GPIO) begin : g_chk_slow_order
        $error("Register regions are not in ascending order");
    end
    if (OFS_GPIO_END > OFS_FCTL || OFS_FCTL >= OFS_REG_END) begin : g_chk_fast_order
        $error("GPIO and flash controller regions overlap");
    end
    if (DW != (8 << LANE_W)) begin : g_chk_lanes
        $error("Byte lane width does not match the data width");
    end

    mmd_state_e state_q, state_d;
    mmd_tgt_e tgt_q, tgt_d;
    mmd_size_e size_q, size_d;
    logic [LANE_W-1:0] lane_q, lane_d;
    logic wr_q, wr_d;
    logic [15:0] lo_q, lo_d;
    logic alias_q, alias_d;
    logic ack_q, ack_d;
    logic [DW-1:0] rdata_q, rdata_d;
    mmd_sram_s sram_q, sram_d;
    mmd_flash_s flash_q, flash_d;
    mmd_reg_s reg_q, reg_d;

    // Address decode of the request on the core bus
    wire [31:0] a = core_req_i.addr;
    wire [LANE_W-1:0] lane = a[LANE_W-1:0];
    wire [REG_OFS_W-1:0] ofs = a[REG_OFS_W-1:0];
    wire [FL_OFS_W-1:0] fl_off = a[FL_OFS_W-1:0];
    wire in_alias = a < ALIAS_LIMIT;
    wire hit_sram_alias = in_alias && !alias_q && a < SRAM_SPAN;
    wire hit_sram_phys = a >= SRAM_BASE && a < SRAM_BASE + SRAM_SPAN;
    wire hit_sram = hit_sram_alias || hit_sram_phys;
    wire hit_flash_alias = in_alias && alias_q;
    wire hit_flash_phys = a >= FL1_BASE && a < FL_END;
    wire hit_flash = hit_flash_alias || hit_flash_phys;
    wire hit_regs = a >= REG_BASE;

    // Both banks share the low offset bits, so alias and physical agree
    localparam logic [FL_OFS_W-1:0] FL0_OFS = FL_OFS_W'(FL0_BASE - FL1_BASE);
    localparam logic [FL_OFS_W-1:0] BOOT_OFS = FL_OFS_W'(FL0_USER_END - FL1_BASE);
    wire fl_bank0 = fl_off >= FL0_OFS;
    wire fl_boot = fl_off >= BOOT_OFS;
    wire [PAGE_W-1:0] fl_page = fl_off[FL_OFS_W-1:PAGE_SHIFT];
    wire [FL_HW_W-1:0] fl_hw = fl_off[FL_OFS_W-1:1];
    wire [FL_HW_W-1:0] fl_hw_word = {fl_off[FL_OFS_W-1:2], 1'b0};
    wire fl_word = core_req_i.size == SZ_WORD;

    // Register-space regions
    wire r_irq = ofs < OFS_SYS;
    wire r_sys = ofs >= OFS_SYS && ofs < OFS_TMR;
    wire r_tmr = ofs >= OFS_TMR && ofs < OFS_PWR;
    wire r_pwr = ofs >= OFS_PWR && ofs < OFS_PSM;
    wire r_psm = ofs >= OFS_PSM && ofs < OFS_SLOW;
    wire r_apb = ofs >= OFS_SLOW && ofs < OFS_GPIO;
    wire r_gpio = ofs >= OFS_GPIO && ofs < OFS_GPIO_END;
    wire r_fctl = ofs >= OFS_FCTL && ofs < OFS_REG_END;
    wire [RG_N-1:0] rsel;
    assign rsel[RG_IRQ] = r_irq;
    assign rsel[RG_SYS] = r_sys;
    assign rsel[RG_TMR] = r_tmr;
    assign rsel[RG_PWR] = r_pwr;
    assign rsel[RG_PSM] = r_psm;
    assign rsel[RG_APB] = r_apb;
    assign rsel[RG_GPIO] = r_gpio;
    assign rsel[RG_FCTL] = r_fctl;
    // Fast bus: interrupt and system control, GPIO, flash controller
    wire rg_fast = r_irq || r_sys || r_gpio || r_fctl;
    wire rg_any = |rsel;
    wire hit_alias_reg = hit_regs && (ofs & OFS_WORD_MASK) == OFS_ALIAS;

    // Little-endian byte lanes: lane n carries address offset n
    wire [4:0] lane_bits = {lane, 3'b000};
    wire [4:0] rlane_bits = {lane_q, 3'b000};
    wire [3:0] be_half = BE_HALF << {lane[1], 1'b0};
    wire [3:0] be_byte = BE_BYTE << lane;
    wire [3:0] be = core_req_i.size == SZ_WORD ? BE_WORD :
                    core_req_i.size == SZ_HALF ? be_half : be_byte;
    wire [DW-1:0] wlane = core_req_i.wdata << lane_bits;
    // Bit 0 lives in byte lane 0; writes that skip that lane leave it alone
    wire alias_wr = core_req_i.write && be[0];

    // Raw word as seen on the 32-bit bus, before right alignment
    wire [DW-1:0] fl_half = lane_q[1] ? {flash_rdata_i, 16'h0000} :
                                        {16'h0000, flash_rdata_i};
    wire [DW-1:0] fl_raw = state_q == ST_FHI ? {flash_rdata_i, lo_q} : fl_half;
    wire [DW-1:0] alias_raw = {{(DW - 1){1'b0}}, alias_q};
    wire [DW-1:0] raw = tgt_q == TG_SRAM ? sram_rdata_i :
                        tgt_q == TG_FLASH ? fl_raw :
                        tgt_q == TG_REG ? reg_rdata_i :
                        tgt_q == TG_ALIAS ? alias_raw : '0;
    wire [DW-1:0] shifted = raw >> rlane_bits;
    wire [DW-1:0] size_mask = size_q == SZ_WORD ? '1 :
                              size_q == SZ_HALF ? MASK_HALF : MASK_BYTE;
    wire [DW-1:0] aligned = shifted & size_mask;
    wire last = state_q == ST_ONE || state_q == ST_SLOW2 || state_q == ST_FHI;

    always_comb begin
        state_d = state_q;
        tgt_d = tgt_q;
        size_d = size_q;
        lane_d = lane_q;
        wr_d = wr_q;
        lo_d = lo_q;
        alias_d = alias_q;
        ack_d = 1'b0;
        rdata_d = rdata_q;
        sram_d = sram_q;
        flash_d = flash_q;
        reg_d = reg_q;
        case (state_q)
            ST_IDLE: begin
                if (core_req_i.valid) begin
                    size_d = core_req_i.size;
                    lane_d = lane;
                    wr_d = core_req_i.write;
                    tgt_d = TG_NONE;
                    state_d = ST_ONE;
                    if (hit_sram) begin
                        tgt_d = TG_SRAM;
                        sram_d.en = 1'b1;
                        sram_d.we = core_req_i.write;
                        sram_d.be = be;
                        sram_d.addr = a[SRAM_AW+1:2];
                        sram_d.wdata = wlane;
                    end else if (hit_flash) begin
                        // Array is read-only here; writes fall through as no-ops
                        if (!core_req_i.write) begin
                            tgt_d = TG_FLASH;
                            flash_d.rd = 1'b1;
                            flash_d.bank0 = fl_bank0;
                            flash_d.boot = fl_boot;
                            flash_d.page = fl_page;
                            flash_d.addr = fl_word ? fl_hw_word : fl_hw;
                            if (fl_word) begin
                                state_d = ST_FLO;
                            end
                        end
                    end else if (hit_alias_reg) begin
                        tgt_d = TG_ALIAS;
                        if (alias_wr) begin
                            alias_d = core_req_i.wdata[ALIAS_BIT];
                        end
                    end else if (hit_regs && rg_any) begin
                        tgt_d = TG_REG;
                        reg_d.sel = rsel;
                        reg_d.we = core_req_i.write;
                        reg_d.be = be;
                        reg_d.addr = ofs;
                        reg_d.wdata = wlane;
                        if (!rg_fast) begin
                            state_d = ST_SLOW1;
                        end
                    end
                end
            end
            ST_SLOW1: begin
                // Peripheral bus keeps the strobe for a second cycle
                state_d = ST_SLOW2;
            end
            ST_FLO: begin
                // Low halfword first, then the next halfword up
                lo_d = flash_rdata_i;
                flash_d.addr = FL_HW_W'(flash_q.addr + 1'b1);
                state_d = ST_FHI;
            end
            ST_ONE, ST_SLOW2, ST_FHI: begin
                state_d = ST_IDLE;
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
        // Last cycle: answer the core and drop every strobe
        if (last) begin
            ack_d = 1'b1;
            rdata_d = wr_q ? '0 : aligned;
            sram_d.en = 1'b0;
            flash_d.rd = 1'b0;
            reg_d.sel = '0;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_q <= ST_IDLE;
            tgt_q <= TG_NONE;
            size_q <= SZ_BYTE;
            lane_q <= '0;
            wr_q <= 1'b0;
            lo_q <= '0;
            alias_q <= ALIAS_RST;
        end else begin
            state_q <= state_d;
            tgt_q <= tgt_d;
            size_q <= size_d;
            lane_q <= lane_d;
            wr_q <= wr_d;
            lo_q <= lo_d;
            alias_q <= alias_d;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ack_q <= 1'b0;
            rdata_q <= '0;
            sram_q <= '0;
            flash_q <= '0;
            reg_q <= '0;
        end else begin
            ack_q <= ack_d;
            rdata_q <= rdata_d;
            sram_q <= sram_d;
            flash_q <= flash_d;
            reg_q <= reg_d;
        end
    end

    assign core_ack_o = ack_q;
    assign core_rdata_o = rdata_q;
    assign alias_flash_o = alias_q;
    assign sram_o = sram_q;
    assign flash_o = flash_q;
    assign reg_o = reg_q;

endmodule

/* include/mmd_pkg.sv */
/*
 Shared constants, enumerations and carrier structs of the memory map
 decoder: region bases, register-space offsets, byte lanes and states.
 Assumes a single 32-bit byte-addressed core bus and one system clock.
*/
package mmd_pkg;

    localparam int unsigned DW = 32;
    localparam int unsigned REG_OFS_W = 16;
    // Both flash banks together span 128 kB
    localparam int unsigned FL_OFS_W = 17;
    localparam int unsigned FL_HW_W = FL_OFS_W - 1;
    // Erase/program pages of 512 bytes
    localparam int unsigned PAGE_SHIFT = 9;
    localparam int unsigned PAGE_W = FL_OFS_W - PAGE_SHIFT;
    localparam int unsigned SRAM_AW = 11;
    localparam int unsigned LANE_W = 2;

    localparam logic [31:0] ALIAS_LIMIT = 32'h0002_0000;
    localparam logic [31:0] SRAM_BASE = 32'h0004_0000;
    localparam logic [31:0] FL1_BASE = 32'h0008_0000;
    localparam logic [31:0] FL0_BASE = 32'h0009_0000;
    localparam logic [31:0] FL0_USER_END = 32'h0009_f700;
    localparam logic [31:0] FL_END = 32'h000a_0000;
    localparam logic [31:0] REG_BASE = 32'hffff_0000;

    localparam logic [15:0] OFS_SYS = 16'h0200;
    localparam logic [15:0] OFS_ALIAS = 16'h0220;
    localparam logic [15:0] OFS_TMR = 16'h0300;
    localparam logic [15:0] OFS_PWR = 16'h0400;
    localparam logic [15:0] OFS_PSM = 16'h0440;
    localparam logic [15:0] OFS_SLOW = 16'h0480;
    localparam logic [15:0] OFS_GPIO = 16'h0d00;
    localparam logic [15:0] OFS_GPIO_END = 16'h0e00;
    localparam logic [15:0] OFS_FCTL = 16'h0f80;
    localparam logic [15:0] OFS_REG_END = 16'h1000;
    localparam logic [15:0] OFS_WORD_MASK = 16'hfffc;

    localparam logic ALIAS_RST = 1'b1;
    localparam int unsigned ALIAS_BIT = 0;

    localparam logic [31:0] MASK_BYTE = 32'h0000_00ff;
    localparam logic [31:0] MASK_HALF = 32'h0000_ffff;
    localparam logic [3:0] BE_BYTE = 4'h1;
    localparam logic [3:0] BE_HALF = 4'h3;
    localparam logic [3:0] BE_WORD = 4'hf;

    localparam int unsigned RG_IRQ = 0;
    localparam int unsigned RG_SYS = 1;
    localparam int unsigned RG_TMR = 2;
    localparam int unsigned RG_PWR = 3;
    localparam int unsigned RG_PSM = 4;
    localparam int unsigned RG_APB = 5;
    localparam int unsigned RG_GPIO = 6;
    localparam int unsigned RG_FCTL = 7;
    localparam int unsigned RG_N = 8;

    typedef enum logic [1:0] {
        SZ_BYTE = 2'b00,
        SZ_HALF = 2'b01,
        SZ_WORD = 2'b10
    } mmd_size_e;

    typedef enum logic [2:0] {
        TG_NONE = 3'b000,
        TG_SRAM = 3'b001,
        TG_FLASH = 3'b010,
        TG_REG = 3'b011,
        TG_ALIAS = 3'b100
    } mmd_tgt_e;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ONE = 3'b001,
        ST_SLOW1 = 3'b010,
        ST_SLOW2 = 3'b011,
        ST_FLO = 3'b100,
        ST_FHI = 3'b101
    } mmd_state_e;

    typedef struct packed {
        logic valid;
        logic write;
        mmd_size_e size;
        logic [31:0] addr;
        logic [DW-1:0] wdata;
    } mmd_req_s;

    typedef struct packed {
        logic en;
        logic we;
        logic [3:0] be;
        logic [SRAM_AW-1:0] addr;
        logic [DW-1:0] wdata;
    } mmd_sram_s;

    typedef struct packed {
        logic rd;
        logic bank0;
        logic boot;
        logic [PAGE_W-1:0] page;
        logic [FL_HW_W-1:0] addr;
    } mmd_flash_s;

    typedef struct packed {
        logic [RG_N-1:0] sel;
        logic we;
        logic [3:0] be;
        logic [REG_OFS_W-1:0] addr;
        logic [DW-1:0] wdata;
    } mmd_reg_s;

endpackage

/* verification/mmd_decoder_assertions.sv */
/* Port timing checker of the decoder.
 Bound to mmd_decoder; sees only its ports. */
`timescale 1ns/10ps
module mmd_decoder_assertions (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic core_ack_o,
    input wire logic alias_flash_o,
    input mmd_pkg::mmd_sram_s sram_o,
    input mmd_pkg::mmd_flash_s flash_o,
    input mmd_pkg::mmd_reg_s reg_o
);
    import mmd_pkg::*;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    chk_alias_reset: assert property ($rose(resetn_i) |-> alias_flash_o)
        else $error("alias not on flash after reset");
    chk_ack_single: assert property (core_ack_o |=> !core_ack_o)
        else $error("ack too long");
    chk_sram_one: assert property (sram_o.en |=> (core_ack_o && !sram_o.en))
        else $error("sram access not one cycle");
    chk_flash_pair: assert property (flash_o.rd && $past(flash_o.rd) |->
        (flash_o.addr == $past(flash_o.addr) + 16'h1) ##1 (core_ack_o && !flash_o.rd))
        else $error("flash word not two reads");
    chk_flash_fields: assert property (flash_o.rd |->
        flash_o.bank0 == flash_o.addr[15] && flash_o.page == flash_o.addr[15:8]
        && flash_o.boot == (flash_o.addr >= 16'hfb80)) else $error("flash fields wrong");
    chk_flash_rate: assert property ($rose(flash_o.rd) |-> ##[1:2] core_ack_o)
        else $error("flash fetch too slow");
    chk_slow_reg: assert property ($rose(|reg_o.sel[5:2]) |=>
        ($stable(reg_o.sel) && $stable(reg_o.addr)) ##1 (core_ack_o && reg_o.sel == '0))
        else $error("slow register not two cycles");
    chk_fast_reg: assert property (|{reg_o.sel[7:6], reg_o.sel[1:0]} |=>
        (core_ack_o && reg_o.sel == '0)) else $error("fast register not one cycle");
    chk_one_target: assert property ($onehot0(reg_o.sel) && !(sram_o.en && flash_o.rd))
        else $error("two targets selected");
    chk_reg_region: assert property (|reg_o.sel[5:2] |-> reg_o.addr >= OFS_TMR
        && reg_o.addr < OFS_GPIO) else $error("slow strobe out of range");
    cover property (sram_o.en && sram_o.we);
    cover property (flash_o.rd ##1 flash_o.rd);
    cover property (!alias_flash_o);
endmodule

/* verification/mmd_target_model.sv */
/* Targets behind the decoder: SRAM array, flash and register patterns.
 Assumes same-clock strobes; unselected read lines carry junk. */
`timescale 1ns/10ps
module mmd_target_model (
    input wire logic clk_i,
    input mmd_pkg::mmd_sram_s sram_i,
    input mmd_pkg::mmd_flash_s flash_i,
    input mmd_pkg::mmd_reg_s reg_i,
    output logic [31:0] sram_rdata_o,
    output logic [15:0] flash_rdata_o,
    output logic [31:0] reg_rdata_o
);
    import mmd_pkg::*;
    logic [31:0] mem [2048];
    logic [31:0] s_q = '0;
    logic [31:0] r_q = '0;
    logic [15:0] f_q = '0;
    logic [15:0] w;
    initial foreach (mem[i]) mem[i] = '0;
    assign w = {reg_i.addr[15:2], 2'b00};
    // Unselected lines flip each cycle so a stale sample never matches
    assign sram_rdata_o = sram_i.en ? mem[sram_i.addr] : ~s_q;
    assign flash_rdata_o = flash_i.rd ? flash_i.addr ^ 16'h5a3c : ~f_q;
    assign reg_rdata_o = |reg_i.sel ? {~w, w} : ~r_q;
    always @(posedge clk_i) begin
        {s_q, f_q, r_q} <= {sram_rdata_o, flash_rdata_o, reg_rdata_o};
        for (int b = 0; b < 4; b++) begin
            if (sram_i.en && sram_i.we && sram_i.be[b]) begin
                mem[sram_i.addr][b*8 +: 8] <= sram_i.wdata[b*8 +: 8];
            end
        end
    end
endmodule

/* verification/mmd_decoder_bench.sv */
/* Directed and random core accesses checked against a map model.
 Assumes mmd_target_model answers every target strobe. */
`timescale 1ns/10ps
module mmd_decoder_bench;
    import mmd_pkg::*;
    logic clk_i = 1'b0;
    logic resetn_i = 1'b0;
    mmd_req_s req = '0;
    logic ack, afl, am;
    logic [31:0] rd, srd, rrd, a, sm [2048];
    logic [15:0] frd;
    mmd_sram_s so;
    mmd_flash_s fo;
    mmd_reg_s ro;
    mmd_size_e sz;
    int mismatches = 0;
    int check_count = 0;
    int k;
    logic [31:0] bs [4] = '{32'h0, SRAM_BASE, FL1_BASE, REG_BASE};
    logic [31:0] sp [4] = '{32'h2_0000, 32'h2000, 32'h2_0000, 32'h1200};
    logic [15:0] rg [8] = '{16'h0, 16'h0200, 16'h0300, 16'h0440, 16'h0d00, 16'h0f80,
        16'h0e00, 16'h1000};
    always #12.5 clk_i = ~clk_i;
    mmd_decoder u_dut (.clk_i(clk_i), .resetn_i(resetn_i), .core_req_i(req),
        .core_ack_o(ack), .core_rdata_o(rd), .alias_flash_o(afl), .sram_o(so),
        .sram_rdata_i(srd), .flash_o(fo), .flash_rdata_i(frd), .reg_o(ro), .reg_rdata_i(rrd));
    mmd_target_model u_mem (.clk_i(clk_i), .sram_i(so), .flash_i(fo), .reg_i(ro),
        .sram_rdata_o(srd), .flash_rdata_o(frd), .reg_rdata_o(rrd));
    function automatic logic [31:0] pick(logic [31:0] w, logic [1:0] l, mmd_size_e s);
        w = w >> {l, 3'b000};
        return s == SZ_BYTE ? w & MASK_BYTE : s == SZ_HALF ? w & MASK_HALF : w;
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test;
        if (mismatches == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic do_reset;
        resetn_i = 1'b0;
        am = 1'b1;
        repeat (8) @(negedge clk_i);
        resetn_i = 1'b1;
    endtask
    task automatic acc(input logic w, input mmd_size_e s, input logic [31:0] ad,
            input logic [31:0] wd);
        logic [31:0] e, x, m;
        logic [15:0] h, o;
        int n, lat;
        logic [3:0] bx;
        logic rw;
        x = '0;
        rw = 1'b0;
        lat = 2;
        // Alias window folds onto flash or the first 8 kB of SRAM, rest unmapped
        e = ad >= ALIAS_LIMIT ? ad : am ? ad + FL1_BASE : ad < 32'h2000 ? ad + SRAM_BASE : '1;
        h = 16'((e - FL1_BASE) >> 1);
        o = e[15:0];
        m = pick('1, 2'b00, s) << {e[1:0], 3'b000};
        bx = s == SZ_WORD ? BE_WORD : (s == SZ_HALF ? BE_HALF : BE_BYTE) << e[1:0];
        if (e >= SRAM_BASE && e < SRAM_BASE + 32'h2000) begin
            if (w) sm[e[12:2]] = sm[e[12:2]] & ~m | wd << {e[1:0], 3'b000} & m;
            x = w ? '0 : pick(sm[e[12:2]], e[1:0], s);
        end else if (e >= FL1_BASE && e < FL_END && !w) begin
            lat = s == SZ_WORD ? 3 : 2;
            x = s == SZ_WORD ? {(h + 16'h1) ^ 16'h5a3c, h ^ 16'h5a3c}
                : pick({16'h0, h ^ 16'h5a3c}, {1'b0, e[0]}, s);
        end else if (e[31:16] == 16'hffff && o[15:2] == OFS_ALIAS[15:2]) begin
            if (w && e[1:0] == 2'b00) am = wd[0];
            x = w ? '0 : pick({31'h0, am}, e[1:0], s);
        end else if (e[31:16] == 16'hffff && o < OFS_REG_END
                && (o < OFS_GPIO_END || o >= OFS_FCTL)) begin
            rw = 1'b1;
            lat = o >= OFS_TMR && o < OFS_GPIO ? 3 : 2;
            x = w ? '0 : pick({~o[15:2], 2'b11, o[15:2], 2'b00}, e[1:0], s);
        end
        @(negedge clk_i);
        req = '{1'b1, w, s, ad, wd};
        n = 0;
        do begin
            @(negedge clk_i);
            n++;
            if (n == 1 && rw) begin
                check(ro.wdata, wd << {e[1:0], 3'b000});
                check({ro.we, ro.be, ro.addr}, {w, bx, o});
            end
        end while (ack !== 1'b1 && n < 6);
        req.valid = 1'b0;
        check(rd, x);
        check(n, lat);
        check(afl, am);
    endtask
    initial begin
        k = $urandom(32'h821e99ca);
        foreach (sm[i]) sm[i] = '0;
        do_reset;
        acc(1'b0, SZ_WORD, 32'h0, '0);
        acc(1'b0, SZ_BYTE, 32'h3, '0);
        acc(1'b0, SZ_WORD, 32'h9f6fc, '0);
        acc(1'b0, SZ_HALF, FL0_USER_END, '0);
        acc(1'b0, SZ_WORD, 32'h8fffc, '0);
        acc(1'b1, SZ_WORD, SRAM_BASE, 32'h4433_2211);
        for (int b = 0; b < 4; b++) acc(1'b0, SZ_BYTE, SRAM_BASE + b, '0);
        foreach (rg[i]) begin
            acc(1'b1, SZ_WORD, REG_BASE + rg[i], 32'h5555_aaaa);
            acc(1'b0, SZ_HALF, REG_BASE + rg[i] + 32'h2, '0);
        end
        acc(1'b1, SZ_BYTE, REG_BASE + OFS_ALIAS, '0);
        acc(1'b0, SZ_WORD, 32'h0, '0);
        acc(1'b0, SZ_WORD, 32'h2000, '0);
        repeat (150) begin
            k = $urandom % 4;
            sz = mmd_size_e'($urandom % 3);
            a = bs[k] + $urandom % sp[k] & ~((32'h1 << sz) - 32'h1);
            acc(1'($urandom % 2), sz, a, pick($urandom, 2'b00, sz));
        end
        do_reset;
        acc(1'b0, SZ_HALF, 32'h6, '0);
        finish_test;
    end
    initial begin
        #250000;
        mismatches++;
        finish_test;
    end
endmodule
bind mmd_decoder mmd_decoder_assertions u_chk (.clk_i(clk_i), .resetn_i(resetn_i),
    .core_ack_o(core_ack_o), .alias_flash_o(alias_flash_o), .sram_o(sram_o),
    .flash_o(flash_o), .reg_o(reg_o));
